// >>> pwmt_pkg.sv
// Package of constants for the two-channel PWM timer
// What this block does
// R01: Counter steps on falling prescaler output edge
// R02: Output-on low holds counter zero, output off
// R03: Output-on low hands pin to port logic
// R04: Stopped counter: duty writes take effect immediately
// R05: Output-on high starts counting from held value
// R06: Active level when count steps zero to one
// R07: Inactive level once count passes duty
// R08: Running: duty write buffered until count wraps
// R09: Polarity bit one inverts the driven output
// R10: Software sets divider, polarity before output-on
// R11: Duty zero keeps output inactive always
// R12: Duty 250 to 255 keeps output active
// R13: Counter runs zero to 249, then wraps
// R14: Divider codes select clock/2 through clock/4096
// R15: Duty read returns the value in use
// R16: Reset: counter zero, duty 0xff, control 0x38
// R17: Two channels run independently, shared prescaler
package pwmt_pkg;
   // ****************************************
   // Register map, byte addresses on APB
   // ****************************************
   localparam logic [11:0] PWMT_CTRL0_ADDR = 12'h000;
   localparam logic [11:0] PWMT_DUTY0_ADDR = 12'h004;
   localparam logic [11:0] PWMT_CNT0_ADDR  = 12'h008;
   localparam logic [11:0] PWMT_CTRL1_ADDR = 12'h010;
   localparam logic [11:0] PWMT_DUTY1_ADDR = 12'h014;
   localparam logic [11:0] PWMT_CNT1_ADDR  = 12'h018;
   localparam logic [11:0] PWMT_CH_STRIDE  = 12'h010;
   localparam logic [11:0] PWMT_OFS_MASK   = 12'h00f;
   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int          PWMT_OE_BIT    = 7;
   localparam int          PWMT_POL_BIT   = 6;
   localparam logic [7:0]  PWMT_RSV_ONES  = 8'h38;
   localparam logic [7:0]  PWMT_CTRL_RST  = 8'h38;
   localparam logic [7:0]  PWMT_DUTY_RST  = 8'hff;
   localparam logic [7:0]  PWMT_CNT_RST   = 8'h00;
   localparam logic [7:0]  PWMT_CNT_TERM  = 8'hf9;
   localparam logic [7:0]  PWMT_CNT_ONE   = 8'h01;
   localparam logic [7:0]  PWMT_DUTY_ZERO = 8'h00;
   localparam logic [7:0]  PWMT_DUTY_FULL = 8'hfa;
   // ****************************************
   // Prescaler
   // ****************************************
   localparam int          PWMT_PRE_W     = 12;
endpackage : pwmt_pkg

// >>> pwmt_chan.sv
// One PWM channel: control, duty buffer, counter and output
`timescale 1ns/1ps
module pwmt_chan
   import pwmt_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  standby,
   input  wire logic [PWMT_PRE_W-1:0] pre_q,
   input  wire logic [PWMT_PRE_W-1:0] pre_d,
   input  wire logic                  wr_ctrl,
   input  wire logic                  wr_duty,
   input  wire logic                  wr_cnt,
   input  wire logic [7:0]            wdata,
   output logic      [7:0]            ctrl_q,
   output logic      [7:0]            duty_q,
   output logic      [7:0]            cnt_q,
   output logic                       pin_q,
   output logic                       pin_en_q
);
   logic [7:0] ctrl_d, duty_d, cnt_d, buf_q, buf_d;
   logic       pin_d, pin_en_d, tick, pend_q, pend_d, act;
   logic [2:0] sel;

   // Falling edge of selected prescaler tap
   always_comb begin
      sel  = ctrl_q[2:0];
      case (sel)
         3'h0:    tick = pre_q[0]  & ~pre_d[0];  // [R14] [R01]
         3'h1:    tick = pre_q[2]  & ~pre_d[2];
         3'h2:    tick = pre_q[4]  & ~pre_d[4];
         3'h3:    tick = pre_q[6]  & ~pre_d[6];
         3'h4:    tick = pre_q[7]  & ~pre_d[7];
         3'h5:    tick = pre_q[9]  & ~pre_d[9];
         3'h6:    tick = pre_q[10] & ~pre_d[10];
         default: tick = pre_q[11] & ~pre_d[11];
      endcase
   end

   // Next state of registers, counter and output
   always_comb begin
      ctrl_d   = ctrl_q;
      duty_d   = duty_q;
      buf_d    = buf_q;
      pend_d   = pend_q;
      cnt_d    = cnt_q;
      act      = 1'b0;
      if (wr_ctrl) ctrl_d = wdata | PWMT_RSV_ONES;
      if (!ctrl_q[PWMT_OE_BIT]) begin
         cnt_d  = PWMT_CNT_RST;                          // [R02]
         pend_d = 1'b0;
         if (wr_duty) duty_d = wdata;                    // [R04]
      end else begin
         if (wr_duty) begin
            buf_d  = wdata;                              // [R08]
            pend_d = 1'b1;
         end
         if (wr_cnt) cnt_d = wdata;
         else if (tick) begin                            // [R05]
            if (cnt_q >= PWMT_CNT_TERM) begin
               cnt_d = PWMT_CNT_RST;                     // [R13]
               if (pend_q) begin
                  duty_d = buf_q;                        // [R08]
                  pend_d = wr_duty;
               end
            end else cnt_d = cnt_q + PWMT_CNT_ONE;
         end
      end
      // Level follows count vs duty
      // Compare against the duty valid after this edge, so a wrap swap never glitches
      if (duty_d == PWMT_DUTY_ZERO) act = 1'b0;          // [R11]
      else if (duty_d >= PWMT_DUTY_FULL) act = 1'b1;     // [R12]
      else act = (cnt_d != PWMT_CNT_RST) && (cnt_d <= duty_d); // [R06] [R07]
      pin_en_d = ctrl_q[PWMT_OE_BIT];                    // [R03]
      pin_d    = ctrl_q[PWMT_OE_BIT] ? (act ^ ctrl_q[PWMT_POL_BIT]) : 1'b0; // [R09]
   end

   // Registers; standby reinitialises like reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= PWMT_CTRL_RST;                      // [R16]
         duty_q   <= PWMT_DUTY_RST;
         buf_q    <= PWMT_DUTY_RST;
         pend_q   <= 1'b0;
         cnt_q    <= PWMT_CNT_RST;
         pin_q    <= 1'b0;
         pin_en_q <= 1'b0;
      end else if (standby) begin
         ctrl_q   <= PWMT_CTRL_RST;                      // [R16]
         duty_q   <= PWMT_DUTY_RST;
         buf_q    <= PWMT_DUTY_RST;
         pend_q   <= 1'b0;
         cnt_q    <= PWMT_CNT_RST;
         pin_q    <= 1'b0;
         pin_en_q <= 1'b0;
      end else begin
         ctrl_q   <= ctrl_d;
         duty_q   <= duty_d;
         buf_q    <= buf_d;
         pend_q   <= pend_d;
         cnt_q    <= cnt_d;
         pin_q    <= pin_d;
         pin_en_q <= pin_en_d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_stop_holds_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
      !ctrl_q[PWMT_OE_BIT] |=> cnt_q == PWMT_CNT_RST)
      else $error("counter not held while stopped");
   a_count_bound: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      $past(cnt_q) <= PWMT_CNT_TERM && !$past(wr_cnt) |-> cnt_q <= PWMT_CNT_TERM)
      else $error("counter beyond terminal");
   a_zero_inactive: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      $past(ctrl_q[PWMT_OE_BIT]) && !$past(standby) && duty_q == PWMT_DUTY_ZERO
      |-> pin_q == $past(ctrl_q[PWMT_POL_BIT]))
      else $error("zero duty not inactive");
   a_direct_duty: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
      !ctrl_q[PWMT_OE_BIT] && wr_duty && !standby |=> duty_q == $past(wdata))
      else $error("stopped duty write not immediate");
   a_hold_duty: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      ctrl_q[PWMT_OE_BIT] && $past(ctrl_q[PWMT_OE_BIT]) && $changed(duty_q) && !$past(standby)
      |-> $past(cnt_q) >= PWMT_CNT_TERM)
      else $error("duty changed outside wrap");
   a_pin_release: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
      !ctrl_q[PWMT_OE_BIT] |=> !pin_en_q)
      else $error("pin driven while disabled");
endmodule : pwmt_chan

// >>> pwmt_top.sv
// APB slave, shared prescaler and two PWM channels
`timescale 1ns/1ps
module pwmt_top
   import pwmt_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        standby,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             pulse_out_ch0,
   output logic             pulse_out_ch0_en,
   output logic             pulse_out_ch1,
   output logic             pulse_out_ch1_en
);
   logic [PWMT_PRE_W-1:0] pre_q, pre_d;
   logic [7:0]            ctrl [2];
   logic [7:0]            duty [2];
   logic [7:0]            cnt  [2];
   logic [1:0]            wc, wd, wt;
   logic                  acc, hit, ch;
   logic [11:0]           ofs;
   logic [31:0]           rd;
   logic                  pin [2];
   logic                  pen [2];

   // Free-running prescaler shared by both channels
   always_comb pre_d = standby ? '0 : pre_q + PWMT_PRE_W'(1); // [R17]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_q <= '0;
      else          pre_q <= pre_d;
   end

   // Address decode; zero-wait access
   always_comb begin
      acc = psel & penable;
      ch  = paddr[4];
      ofs = paddr & PWMT_OFS_MASK;
      hit = (paddr[11:5] == 7'h00) && (ofs == PWMT_CTRL0_ADDR || ofs == PWMT_DUTY0_ADDR || ofs == PWMT_CNT0_ADDR);
      wc  = '0;
      wd  = '0;
      wt  = '0;
      wc[ch] = acc & pwrite & hit & (ofs == PWMT_CTRL0_ADDR);
      wd[ch] = acc & pwrite & hit & (ofs == PWMT_DUTY0_ADDR);
      wt[ch] = acc & pwrite & hit & (ofs == PWMT_CNT0_ADDR);
      rd  = '0;
      if (hit) begin
         case (ofs)
            PWMT_CTRL0_ADDR: rd = {24'h000000, ctrl[ch]};
            PWMT_DUTY0_ADDR: rd = {24'h000000, duty[ch]}; // [R15]
            default:         rd = {24'h000000, cnt[ch]};
         endcase
      end
   end

   // Read data and response registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= (psel & ~penable & ~pwrite) ? rd : prdata;
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
      end
   end

   // Two independent channels
   for (genvar i = 0; i < 2; i++) begin : g_ch
      pwmt_chan u_ch (
         .pclk     (pclk),
         .presetn  (presetn),
         .standby  (standby),
         .pre_q    (pre_q),
         .pre_d    (pre_d),
         .wr_ctrl  (wc[i]),
         .wr_duty  (wd[i]),
         .wr_cnt   (wt[i]),
         .wdata    (pwdata[7:0]),
         .ctrl_q   (ctrl[i]),
         .duty_q   (duty[i]),
         .cnt_q    (cnt[i]),
         .pin_q    (pin[i]),
         .pin_en_q (pen[i])
      );
   end
   assign pulse_out_ch0    = pin[0];
   assign pulse_out_ch0_en = pen[0];
   assign pulse_out_ch1    = pin[1];
   assign pulse_out_ch1_en = pen[1];
endmodule : pwmt_top

// >>> pwmt_load.sv
// Load model on one PWM output pin, with port logic level when released
`timescale 1ns/1ps
module pwmt_load #(
   parameter logic PORT_LEVEL = 1'b1
) (
   input  wire logic pclk,
   input  wire logic pulse,
   input  wire logic pulse_en,
   output wire logic pin,
   output int        hi_cnt
);
   // Pin level: PWM when enabled, port logic otherwise
   assign pin = pulse_en ? pulse : PORT_LEVEL;
   // Cycles spent with the pin high; an unknown level spoils the count
   initial hi_cnt = 0;
   always @(posedge pclk) begin
      hi_cnt <= hi_cnt + ((pin === 1'b1) ? 1 : (pin === 1'b0) ? 0 : 100000);
   end
endmodule : pwmt_load

// >>> pwmt_top_bench.sv
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ps
module pwmt_top_bench;
   import pwmt_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, standby = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sl;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, pin0, pin1;
   logic        pulse_out_ch0, pulse_out_ch0_en, pulse_out_ch1, pulse_out_ch1_en;
   int          hi0, hi1, h0, h1, err_count = 0, check_count = 0, p, c;
   int          duty_q[$] = '{0, 1, 125, 250, 255};
   int          divs[8] = '{2, 8, 32, 128, 256, 1024, 2048, 4096};

   // ****************************************
   // Design, loads and helpers
   // ****************************************
   pwmt_top i_dut (.pclk, .presetn, .standby, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                   .pready, .pslverr, .pulse_out_ch0, .pulse_out_ch0_en, .pulse_out_ch1, .pulse_out_ch1_en);
   pwmt_load i_load0 (.pclk, .pulse(pulse_out_ch0), .pulse_en(pulse_out_ch0_en), .pin(pin0), .hi_cnt(hi0));
   pwmt_load i_load1 (.pclk, .pulse(pulse_out_ch1), .pulse_en(pulse_out_ch1_en), .pin(pin1), .hi_cnt(hi1));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      sl = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // High-cycle expectation for one period of a channel
   function automatic int act(input int du, input int dv, input int pol);
      int a;
      a = (du == 0) ? 0 : (du >= 250) ? 250 * dv : du * dv;
      return pol ? 250 * dv - a : a;
   endfunction : act

   task automatic meas(input int n);
      int s0 = hi0;
      int s1 = hi1;
      repeat (n) @(posedge pclk);
      h0 = hi0 - s0;
      h1 = hi1 - s1;
   endtask : meas

   task automatic chk_rst();
      logic [11:0] a[7] = '{PWMT_CTRL0_ADDR, PWMT_DUTY0_ADDR, PWMT_CNT0_ADDR, PWMT_CTRL1_ADDR,
                            PWMT_DUTY1_ADDR, PWMT_CNT1_ADDR, 12'h00c};
      logic [7:0]  v[7] = '{8'h38, 8'hff, 8'h00, 8'h38, 8'hff, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, a[i], 32'h0);
         chk(rd, {24'h0, v[i]});
         chk(sl, i == 6);
      end
      chk({pin0, pulse_out_ch0}, 2'b10);
      chk({pin1, pulse_out_ch1}, 2'b10);
   endtask : chk_rst

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // Clock and watchdog
   always #2.5 pclk = ~pclk;
   initial begin
      repeat (90000) @(posedge pclk);
      err_count++;
      final_report();
   end

   // Main sequence
   initial begin
      c = $urandom(32'h0d27);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_rst();
      $display("reset test done");
      c = $urandom_range(249, 1);
      apb(1'b1, PWMT_CTRL0_ADDR, 32'h0);
      apb(1'b1, PWMT_DUTY0_ADDR, c);
      apb(1'b0, PWMT_DUTY0_ADDR, 32'h0);
      chk(rd, c);
      apb(1'b0, PWMT_CTRL0_ADDR, 32'h0);
      chk(rd, 32'h38);
      $display("stopped test done");
      apb(1'b1, PWMT_CTRL1_ADDR, 32'h1);
      foreach (duty_q[i]) begin
         p = $urandom_range(1, 0);
         apb(1'b1, PWMT_DUTY0_ADDR, duty_q[i]);
         apb(1'b1, PWMT_DUTY1_ADDR, duty_q[4 - i]);
         apb(1'b1, PWMT_CTRL0_ADDR, p * 64);
         apb(1'b1, PWMT_CTRL0_ADDR, 128 + p * 64);
         apb(1'b1, PWMT_CTRL1_ADDR, 32'h81);
         repeat (2100) @(posedge pclk);
         chk({pulse_out_ch0_en, pulse_out_ch1_en}, 2'b11);
         meas(2000);
         chk(h0, 4 * act(duty_q[i], 2, p));
         chk(h1, act(duty_q[4 - i], 8, 0));
         apb(1'b1, PWMT_CTRL0_ADDR, p * 64);
         apb(1'b1, PWMT_CTRL1_ADDR, 32'h1);
      end
      $display("duty test done");
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, PWMT_CTRL0_ADDR, k);
         apb(1'b1, PWMT_CTRL0_ADDR, 128 + k);
         apb(1'b0, PWMT_CNT0_ADDR, 32'h0);
         c = int'(rd);
         repeat (3 * divs[k] - 3) @(posedge pclk);
         apb(1'b0, PWMT_CNT0_ADDR, 32'h0);
         chk((int'(rd) - c + 250) % 250, 3);
      end
      $display("divider test done");
      apb(1'b1, PWMT_CTRL0_ADDR, 32'h0);
      apb(1'b1, PWMT_DUTY0_ADDR, 32'd50);
      apb(1'b1, PWMT_CTRL0_ADDR, 32'h80);
      do apb(1'b0, PWMT_CNT0_ADDR, 32'h0); while (rd > 200);
      apb(1'b1, PWMT_DUTY0_ADDR, 32'd200);
      apb(1'b0, PWMT_DUTY0_ADDR, 32'h0);
      chk(rd, 32'd50);
      repeat (600) @(posedge pclk);
      apb(1'b0, PWMT_DUTY0_ADDR, 32'h0);
      chk(rd, 32'd200);
      $display("buffer test done");
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      @(posedge pclk);
      chk_rst();
      $display("standby test done");
      final_report();
   end
endmodule : pwmt_top_bench
